// *** hw/loop_framer_pkg.sv ***
/*
 * Constants, field sequence, frame tracking struct and the bit-serial
 * CRC/field stepping function shared by the receive and transmit paths
 * of the loop message framer.
 * Assumes messages are whole octets, sent most significant bit first.
 */
package loop_framer_pkg;

    // ****************************************************************
    // Constants
    // ****************************************************************
    // Generator without its x^8 term
    localparam logic [7:0] OCTET_CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // Group size N; other legal sizes are 2, 4 and 16
    localparam logic [7:0] CRC_GROUP = 8'h08;
    localparam logic [7:0] GROUP_MASK = CRC_GROUP - 8'h01;
    // Length code of a fixed length message (eight data octets)
    localparam logic [7:0] FIXED_LEN_CODE = 8'h07;
    // Identification bit that marks variable length data
    localparam int MSGID_VAR_BIT = 0;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // ****************************************************************
    // Types
    // ****************************************************************
    // Field currently on the line
    typedef enum logic [3:0] {
        F_ADDR = 4'h0,
        F_MSGID = 4'h1,
        F_HCRC = 4'h2,
        F_LEN = 4'h3,
        F_ROUTE = 4'h4,
        F_LCRC = 4'h5,
        F_DATA = 4'h6,
        F_DCRC = 4'h7,
        F_END = 4'h8
    } field_e;

    // Position of one direction within a message
    typedef struct packed {
        field_e field;        // Field in progress
        logic [2:0] bit_cnt;  // Bit within octet
        logic [7:0] crc;      // Running CRC
        logic [7:0] octet;    // Octet being assembled
        logic [7:0] remain;   // Data octets left minus one
        logic var_len;        // Variable length message
        logic last;           // Last data octet done; final data CRC under way
    } frame_s;

    localparam frame_s FRAME_RESET = '{field: F_ADDR, bit_cnt: 3'h0,
        crc: CRC_INIT, octet: 8'h00, remain: 8'h00, var_len: 1'b0,
        last: 1'b0};

    // ****************************************************************
    // Functions
    // ****************************************************************
    // True while a CRC octet is on the line
    function automatic logic is_crc(field_e f);
        return (f == F_HCRC) || (f == F_LCRC) || (f == F_DCRC);
    endfunction : is_crc

    // Advance one bit: CRC shift and field sequencing
    function automatic frame_s frame_bit(frame_s f, logic b);
        frame_s n;
        logic [7:0] oct;
        n = f;
        oct = {f.octet[6:0], b};
        n.octet = oct;
        // Feeding a CRC octet drives the register back to zero
        n.crc = {f.crc[6:0], 1'b0} ^
            ((f.crc[7] ^ b) ? OCTET_CRC_POLY : 8'h00);
        n.bit_cnt = f.bit_cnt + 3'h1;
        if (f.bit_cnt == LAST_BIT) begin
            unique case (f.field)
                F_ADDR: n.field = F_MSGID;
                F_MSGID: begin
                    n.field = F_HCRC;
                    n.var_len = oct[MSGID_VAR_BIT];
                end
                F_HCRC: begin
                    n.field = f.var_len ? F_LEN : F_DATA;
                    n.remain = FIXED_LEN_CODE;
                end
                F_LEN: begin
                    n.field = F_ROUTE;
                    n.remain = oct;
                end
                F_ROUTE: n.field = F_LCRC;
                F_LCRC: n.field = F_DATA;
                F_DATA: begin
                    n.last = (f.remain == 8'h00);
                    if (!n.last) begin
                        n.remain = f.remain - 8'h01;
                    end
                    n.field = ((f.remain & GROUP_MASK) == 8'h00) ?
                        F_DCRC : F_DATA;
                end
                F_DCRC: n.field = f.last ? F_END : F_DATA;
                F_END: n.field = F_END;
                default: n.field = F_END;
            endcase
        end
        return n;
    endfunction : frame_bit

endpackage : loop_framer_pkg

// *** hw/loop_message_crc_framer.sv ***
/*
 * Message framer of a station's communication interface unit: receives
 * messages from the loop line, strips and checks CRC fields and passes
 * content to the device side; takes content from the device side bit
 * by bit, inserts CRC fields and sends it to the reply line.
 * Assumes line clock, line data and line frame arrive asynchronously,
 * line data is stable around the line clock rising edge, and the device
 * side runs on sys_clk and answers a bit request within half a line bit.
 */
`timescale 1ns/1ps

module loop_message_crc_framer
    import loop_framer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    // Line side
    input wire logic line_clk,
    input wire logic line_rx_data,
    input wire logic line_rx_frame,
    output logic line_tx_data,
    output logic line_tx_frame,
    // Device side, receive
    output logic rx_msg_present,
    output logic rx_data,
    output logic rx_strobe,
    output logic rx_error,
    // Device side, transmit
    input wire logic tx_msg_present,
    input wire logic tx_data,
    input wire logic tx_strobe,
    output logic tx_bit_req
);

    // ****************************************************************
    // Line input synchroniser and edge finder
    // ****************************************************************
    logic [2:0] sync1_reg; // First stage, read only by second
    logic [2:0] sync2_reg; // {frame, data, clock}
    logic clk_q_reg;       // Previous synchronised line clock
    logic [2:0] sync1_next;
    logic [2:0] sync2_next;
    logic clk_q_next;
    logic line_rise;
    logic line_fall;

    // Next values of the synchroniser
    always_comb begin
        sync1_next = {line_rx_frame, line_rx_data, line_clk};
        sync2_next = sync1_reg;
        clk_q_next = sync2_reg[0];
    end

    // Registers of the synchroniser
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            clk_q_reg <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            clk_q_reg <= clk_q_next;
        end
    end

    // Edges of the common line clock pace both directions
    assign line_rise = sync2_reg[0] & ~clk_q_reg;
    assign line_fall = ~sync2_reg[0] & clk_q_reg;

    // ****************************************************************
    // Receive path
    // ****************************************************************
    frame_s rx_frame_reg;    // Receive position
    logic rx_active_reg;     // Message in progress
    logic rx_msg_present_reg;
    logic rx_data_reg;
    logic rx_strobe_reg;
    logic rx_error_reg;
    frame_s rx_frame_next;
    logic rx_active_next;
    logic rx_msg_present_next;
    logic rx_data_next;
    logic rx_strobe_next;
    logic rx_error_next;
    frame_s rx_step;         // Position after the sampled bit

    // Next values of the receive path
    always_comb begin
        rx_frame_next = rx_frame_reg;
        rx_active_next = rx_active_reg;
        rx_msg_present_next = rx_msg_present_reg;
        rx_data_next = rx_data_reg;
        rx_strobe_next = 1'b0;
        rx_error_next = rx_error_reg;
        rx_step = frame_bit(rx_frame_reg, sync2_reg[1]);
        if (!rx_active_reg) begin
            // New message: fresh CRC, error cleared
            if (sync2_reg[2]) begin
                rx_active_next = 1'b1;
                rx_msg_present_next = 1'b1;
                rx_frame_next = FRAME_RESET;
                rx_error_next = 1'b0;
            end
        end else if (!sync2_reg[2]) begin
            // Frame ended; a cut short message counts as an error
            rx_active_next = 1'b0;
            rx_msg_present_next = 1'b0;
            if (rx_frame_reg.field != F_END) begin
                rx_error_next = 1'b1;
            end
        end else if (line_rise && (rx_frame_reg.field != F_END)) begin
            rx_frame_next = rx_step;
            if (is_crc(rx_frame_reg.field)) begin
                // CRC octets go no further than this block
                if ((rx_frame_reg.bit_cnt == LAST_BIT) &&
                    (rx_step.crc != CRC_INIT)) begin
                    rx_error_next = 1'b1;
                end
            end else begin
                // Content, route included, is passed as it arrives
                rx_data_next = sync2_reg[1];
                rx_strobe_next = 1'b1;
            end
        end
    end

    // Registers of the receive path
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rx_frame_reg <= FRAME_RESET;
            rx_active_reg <= 1'b0;
            rx_msg_present_reg <= 1'b0;
            rx_data_reg <= 1'b0;
            rx_strobe_reg <= 1'b0;
            rx_error_reg <= 1'b0;
        end else begin
            rx_frame_reg <= rx_frame_next;
            rx_active_reg <= rx_active_next;
            rx_msg_present_reg <= rx_msg_present_next;
            rx_data_reg <= rx_data_next;
            rx_strobe_reg <= rx_strobe_next;
            rx_error_reg <= rx_error_next;
        end
    end

    // ****************************************************************
    // Transmit path
    // ****************************************************************
    frame_s tx_frame_reg;    // Transmit position
    logic tx_active_reg;     // Message on the reply line
    logic tx_armed_reg;      // Message present seen low since last
    logic tx_hold_reg;       // Last bit offered by the device
    logic tx_bit_req_reg;
    logic line_tx_data_reg;
    logic line_tx_frame_reg;
    frame_s tx_frame_next;
    logic tx_active_next;
    logic tx_armed_next;
    logic tx_hold_next;
    logic tx_bit_req_next;
    logic line_tx_data_next;
    logic line_tx_frame_next;
    logic tx_bit;            // Bit driven at this falling edge

    // Next values of the transmit path
    always_comb begin
        tx_frame_next = tx_frame_reg;
        tx_active_next = tx_active_reg;
        tx_armed_next = tx_armed_reg | ~tx_msg_present;
        tx_hold_next = tx_hold_reg;
        tx_bit_req_next = 1'b0;
        line_tx_data_next = line_tx_data_reg;
        line_tx_frame_next = line_tx_frame_reg;
        tx_bit = is_crc(tx_frame_reg.field) ? tx_frame_reg.crc[7] :
            tx_hold_reg;
        // Only the device side starts a send; receive errors never do
        if (!tx_active_reg && tx_armed_reg && tx_msg_present &&
            line_rise) begin
            tx_active_next = 1'b1;
            tx_armed_next = 1'b0;
            tx_frame_next = FRAME_RESET;
            tx_bit_req_next = 1'b1;
        end else if (tx_active_reg && line_rise &&
            (tx_frame_reg.field != F_END) &&
            !is_crc(tx_frame_reg.field)) begin
            // One request per content bit, none for CRC bits, answered before the fall
            tx_bit_req_next = 1'b1;
        end
        // Device answer is caught whenever it comes
        if (tx_strobe) begin
            tx_hold_next = tx_data;
        end
        if (tx_active_reg && line_fall) begin
            if (tx_frame_reg.field == F_END) begin
                // Last CRC bit has had its rising edge; close frame
                tx_active_next = 1'b0;
                line_tx_frame_next = 1'b0;
                line_tx_data_next = 1'b0;
            end else begin
                // CRC octets are shifted out of the register itself
                line_tx_data_next = tx_bit;
                line_tx_frame_next = 1'b1;
                tx_frame_next = frame_bit(tx_frame_reg, tx_bit);
            end
        end
    end

    // Registers of the transmit path
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tx_frame_reg <= FRAME_RESET;
            tx_active_reg <= 1'b0;
            tx_armed_reg <= 1'b0;
            tx_hold_reg <= 1'b0;
            tx_bit_req_reg <= 1'b0;
            line_tx_data_reg <= 1'b0;
            line_tx_frame_reg <= 1'b0;
        end else begin
            tx_frame_reg <= tx_frame_next;
            tx_active_reg <= tx_active_next;
            tx_armed_reg <= tx_armed_next;
            tx_hold_reg <= tx_hold_next;
            tx_bit_req_reg <= tx_bit_req_next;
            line_tx_data_reg <= line_tx_data_next;
            line_tx_frame_reg <= line_tx_frame_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign line_tx_data = line_tx_data_reg;
    assign line_tx_frame = line_tx_frame_reg;
    assign rx_msg_present = rx_msg_present_reg;
    assign rx_data = rx_data_reg;
    assign rx_strobe = rx_strobe_reg;
    assign rx_error = rx_error_reg;
    assign tx_bit_req = tx_bit_req_reg;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    // Strobes to the device side are single pulses
    a_rx_strobe_pulse: assert property (@(posedge sys_clk) disable iff
        (!rst_n) rx_strobe_reg |=> !rx_strobe_reg)
        else $error("receive strobe longer than one cycle");

    a_bit_req_pulse: assert property (@(posedge sys_clk) disable iff
        (!rst_n) tx_bit_req_reg |=> !tx_bit_req_reg)
        else $error("bit request longer than one cycle");

    // No CRC bit reaches the device side
    a_crc_stripped: assert property (@(posedge sys_clk) disable iff
        (!rst_n) rx_strobe_reg |->
        !is_crc($past(rx_frame_reg.field)))
        else $error("CRC bit passed to device side");

    // Error stays up to the end of the message
    a_error_sticky: assert property (@(posedge sys_clk) disable iff
        (!rst_n) (rx_error_reg && rx_active_reg) |=> rx_error_reg)
        else $error("receive error dropped inside a message");

    // Every message starts at the address with a zero CRC
    a_crc_cleared: assert property (@(posedge sys_clk) disable iff
        (!rst_n) $rose(rx_msg_present_reg) |->
        (rx_frame_reg.crc == CRC_INIT) &&
        (rx_frame_reg.field == F_ADDR))
        else $error("receive message did not start clean");

    // CRC bits on the line come from the CRC register
    a_tx_crc_bit: assert property (@(posedge sys_clk) disable iff
        (!rst_n) (tx_active_reg && line_fall &&
        is_crc(tx_frame_reg.field)) |=>
        (line_tx_data_reg == $past(tx_frame_reg.crc[7])))
        else $error("transmitted CRC bit wrong");

    // Only fixed length messages skip to data after the header CRC
    a_fixed_skip: assert property (@(posedge sys_clk) disable iff
        (!rst_n) ($past(rx_frame_reg.field) == F_HCRC &&
        rx_frame_reg.field == F_DATA) |-> !rx_frame_reg.var_len)
        else $error("variable length message skipped length field");

    // Data CRC points fall where the residue is zero
    a_group_point: assert property (@(posedge sys_clk) disable iff
        (!rst_n) ($past(rx_frame_reg.field) == F_DATA &&
        rx_frame_reg.field == F_DCRC) |->
        (($past(rx_frame_reg.remain) & GROUP_MASK) == 8'h00))
        else $error("data CRC at wrong position");

    // No strobe outside a message
    a_strobe_in_msg: assert property (@(posedge sys_clk) disable iff
        (!rst_n) rx_strobe_reg |-> rx_msg_present_reg)
        else $error("receive strobe outside a message");

endmodule : loop_message_crc_framer

// *** verification/loop_line_partner.sv ***
/*
 * Behavioural model of the bus coupler and the remote stations on the
 * loop: makes the line clock, sends framed messages bit by bit and
 * captures what the framer sends back on the reply line.
 * Assumes the bench calls its tasks one at a time, never overlapping.
 */
`timescale 1ns/1ps

module loop_line_partner (
    output logic line_clk,
    output logic line_rx_data,
    output logic line_rx_frame,
    input wire logic line_tx_data,
    input wire logic line_tx_frame
);
    // ****************************************************************
    // State
    // ****************************************************************
    // Reply bits captured at line clock rises while the framer sends
    logic cap[$];

    // Line idle and clock stopped at start
    initial begin
        line_clk = 1'b0;
        line_rx_data = 1'b0;
        line_rx_frame = 1'b0;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Send the first n bits of b; clock runs only inside the frame
    task automatic send(input logic b[$], input int n);
        for (int i = 0; i < n; i++) begin
            #40 line_rx_data = b[i];
            line_rx_frame = 1'b1;
            #40 line_clk = 1'b1;
            #80 line_clk = 1'b0;
        end
        // Released data shows the inverse, never a stale bit
        #40 line_rx_data = ~line_rx_data;
        #40 line_rx_frame = 1'b0;
    endtask : send

    // Run n line clocks with no frame, capturing the reply line
    task automatic run(input int n);
        for (int i = 0; i < n; i++) begin
            #40 line_rx_data = ~line_rx_data;
            #40 line_clk = 1'b1;
            if (line_tx_frame === 1'b1) begin
                cap.push_back(line_tx_data);
            end
            #80 line_clk = 1'b0;
        end
    endtask : run

endmodule : loop_line_partner

// *** verification/loop_message_crc_framer_tb_top.sv ***
/*
 * Self-checking bench of the loop message framer: the partner model
 * plays the line, the bench plays the device side.
 * Assumes the design package and the framer are compiled first.
 */
`timescale 1ns/1ps

module loop_message_crc_framer_tb_top
    import loop_framer_pkg::*;
;
    // ****************************************************************
    // Signals and bench state
    // ****************************************************************
    logic sys_clk; // 200 MHz
    logic rst_n; // Synchronous, active low
    logic line_clk, line_rx_data, line_rx_frame;
    logic line_tx_data, line_tx_frame;
    logic rx_msg_present, rx_data, rx_strobe, rx_error;
    logic tx_msg_present, tx_data, tx_strobe, tx_bit_req;
    logic line_q[$]; // Expected line bits, CRC octets included
    logic cont_q[$]; // Expected content bits, no CRC
    logic got_q[$]; // Content bits strobed to the device
    logic dev_q[$]; // Bits the device still has to send
    logic [7:0] crc_acc; // Running CRC of the group being built
    int failures;
    int n_tests;
    int req_n; // Bit requests seen
    logic tx_seen; // Reply line framed at any time

    // ****************************************************************
    // Instances and clock
    // ****************************************************************
    loop_message_crc_framer loop_message_crc_framer_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .line_clk(line_clk),
        .line_rx_data(line_rx_data), .line_rx_frame(line_rx_frame),
        .line_tx_data(line_tx_data), .line_tx_frame(line_tx_frame),
        .rx_msg_present(rx_msg_present), .rx_data(rx_data),
        .rx_strobe(rx_strobe), .rx_error(rx_error),
        .tx_msg_present(tx_msg_present), .tx_data(tx_data),
        .tx_strobe(tx_strobe), .tx_bit_req(tx_bit_req));

    loop_line_partner loop_line_partner_inst (
        .line_clk(line_clk), .line_rx_data(line_rx_data),
        .line_rx_frame(line_rx_frame), .line_tx_data(line_tx_data),
        .line_tx_frame(line_tx_frame));

    // Free-running system clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ****************************************************************
    // Monitors and device model
    // ****************************************************************
    // Collect content bits and note any reply traffic
    always @(posedge sys_clk) begin
        if (rx_strobe === 1'b1) got_q.push_back(rx_data);
        if (line_tx_frame === 1'b1) tx_seen = 1'b1;
    end

    // Device answers each request with one bit and a strobe
    always @(posedge sys_clk) begin
        if (tx_bit_req === 1'b1) begin
            req_n = req_n + 1;
            #1;
            tx_data = (dev_q.size() > 0) ? dev_q.pop_front() : 1'b0;
            tx_strobe = 1'b1;
            @(posedge sys_clk);
            #1;
            tx_strobe = 1'b0;
            // Message done: drop present, which also re-arms the block
            if (dev_q.size() == 0) tx_msg_present = 1'b0;
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // One compare, counted; mismatches reported at once
    task automatic chk(input string name, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            $display("ERROR %s expected %0h seen %0h", name, e, g);
            failures++;
        end
    endtask : chk

    // Add one octet MSB first and fold it into the CRC
    task automatic add(input logic [7:0] v, input logic is_crc);
        logic fb;
        for (int j = 7; j >= 0; j--) begin
            line_q.push_back(v[j]);
            if (!is_crc) cont_q.push_back(v[j]);
            fb = crc_acc[7] ^ v[j];
            crc_acc = {crc_acc[6:0], 1'b0} ^ (fb ? OCTET_CRC_POLY : 8'h00);
        end
    endtask : add

    // Close a group: its CRC goes out, register restarts at zero
    task automatic addc();
        add(crc_acc, 1'b1);
        crc_acc = 8'h00;
    endtask : addc

    // Build the expected message for a given identification and length
    task automatic build(input logic [7:0] msgid, input logic [7:0] len);
        int l;
        line_q.delete();
        cont_q.delete();
        crc_acc = 8'h00;
        add(8'h5A, 1'b0);
        add(msgid, 1'b0);
        addc();
        l = msgid[0] ? int'(len) : 7;
        if (msgid[0]) begin
            add(len, 1'b0);
            add(8'hC3, 1'b0);
            addc();
        end
        for (int i = 0; i <= l; i++) begin
            add(8'(i * 29) ^ 8'hA5, 1'b0);
            if (((l - i) & 7) == 0) addc();
        end
    endtask : build

    // Bounded wait for the end of a received message
    task automatic wait_idle();
        int k;
        k = 0;
        while (rx_msg_present !== 1'b0 && k < 200) begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 200) begin
            $display("ERROR rx_msg_present expected 0 seen 1");
            failures++;
            results();
        end
    endtask : wait_idle

    // Mismatching positions between two bit queues
    function automatic int diff(input logic a[$], input logic b[$]);
        int n;
        n = 0;
        for (int i = 0; i < a.size() && i < b.size(); i++) begin
            if (a[i] !== b[i]) n++;
        end
        return n;
    endfunction : diff

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Receive; flip one line bit or cut the frame when asked
    task automatic rx_msg(input string name, input logic [7:0] msgid,
                          input logic [7:0] len, input int flip,
                          input int cflip, input int cut,
                          input logic exp_err);
        build(msgid, len);
        if (flip >= 0) line_q[flip] = ~line_q[flip];
        // A flipped content bit still reaches the device as received
        if (cflip >= 0) cont_q[cflip] = ~cont_q[cflip];
        got_q.delete();
        tx_seen = 1'b0;
        // Line pins move off the sampling edge of sys_clk
        #1;
        loop_line_partner_inst.send(line_q,
            (cut > 0) ? cut : line_q.size());
        wait_idle();
        @(posedge sys_clk);
        chk({name, " rx_error"}, 16'(exp_err), 16'(rx_error));
        if (cut == 0) begin
            chk({name, " bits"}, 16'(cont_q.size()),
                16'(got_q.size()));
            chk({name, " content"}, 16'h0000,
                16'(diff(cont_q, got_q)));
        end
        chk({name, " reply"}, 16'h0000, 16'(tx_seen));
        $display("test %s done", name);
    endtask : rx_msg

    // Device sends; the framer must insert every CRC octet
    task automatic tx_msg(input string name, input logic [7:0] msgid,
                          input logic [7:0] len);
        build(msgid, len);
        dev_q = cont_q;
        req_n = 0;
        loop_line_partner_inst.cap.delete();
        @(posedge sys_clk);
        #1 tx_msg_present = 1'b1;
        loop_line_partner_inst.run(line_q.size() + 6);
        chk({name, " requests"}, 16'(cont_q.size()),
            16'(req_n));
        chk({name, " line bits"}, 16'(line_q.size()),
            16'(loop_line_partner_inst.cap.size()));
        chk({name, " line data"}, 16'h0000,
            16'(diff(line_q, loop_line_partner_inst.cap)));
        chk({name, " frame end"}, 16'h0000, 16'(line_tx_frame));
        $display("test %s done", name);
    endtask : tx_msg

    // Verdict, in one place
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        failures = 0;
        n_tests = 0;
        rst_n = 1'b0;
        tx_msg_present = 1'b0;
        tx_data = 1'b0;
        tx_strobe = 1'b0;
        repeat (16) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (8) @(posedge sys_clk);
        chk("rx_msg_present reset", 16'h0000, 16'(rx_msg_present));
        rx_msg("rx variable h2", 8'h03, 8'h09, -1, -1, 0, 1'b0);
        rx_msg("rx variable h1", 8'h03, 8'h10, -1, -1, 0, 1'b0);
        rx_msg("rx variable min", 8'h03, 8'h00, -1, -1, 0, 1'b0);
        rx_msg("rx fixed", 8'h02, 8'h00, -1, -1, 0, 1'b0);
        rx_msg("rx bad crc", 8'h03, 8'h09, 20, -1, 0, 1'b1);
        rx_msg("rx bad data", 8'h02, 8'h00, 30, 22, 0, 1'b1);
        rx_msg("rx truncated", 8'h03, 8'h09, -1, -1, 40, 1'b1);
        rx_msg("rx after error", 8'h02, 8'h00, -1, -1, 0, 1'b0);
        tx_msg("tx variable min", 8'h03, 8'h00);
        tx_msg("tx variable h2", 8'h03, 8'h09);
        tx_msg("tx fixed", 8'h02, 8'h00);
        results();
    end

endmodule : loop_message_crc_framer_tb_top
